// ---- design/mior_cfg.svh ----
// Purpose: Constants for the multi-wire flash read block
// Assumes: 25 MHz system clock, serial clock sampled as a plain input
// Notes: Definitions only
`ifndef MIOR_CFG_SVH
`define MIOR_CFG_SVH

`define MIOR_CLK_HZ 25000000
`define MIOR_OP_DUAL 8'h3B
`define MIOR_OP_DUAL_W 8'h3C
`define MIOR_OP_QUAD 8'h6B
`define MIOR_OP_QUAD_W 8'h6C
`define MIOR_OP_DIO 8'hBB
`define MIOR_OP_DIO_W 8'hBC
`define MIOR_MODE_CONT 4'hA
`define MIOR_ARRAY_TOP 32'h03FFFFFF
`define MIOR_CLKS_A3_1 6'h18
`define MIOR_CLKS_A4_1 6'h20
`define MIOR_CLKS_A3_2 6'h0C
`define MIOR_CLKS_A4_2 6'h10
`define MIOR_MODE_CLKS 6'h04
`define MIOR_LAT_NO_DUMMY 2'h3
`define MIOR_DUMMY_OUT 6'h08
`define MIOR_DUMMY_DIO 6'h04
`define MIOR_SHORT_FRAME 4'h8
`define MIOR_FIFO_DEPTH 16
`define MIOR_FIFO_WIDTH 8

`endif

// ---- design/mior_pkg.sv ----
// Purpose: Types for the multi-wire flash read block
// Assumes: Constants come from mior_cfg.svh
// Notes: Types only
package mior_pkg;
    typedef enum logic [2:0] {
        PH_OPCODE = 3'h0,
        PH_ADDR = 3'h1,
        PH_MODE = 3'h2,
        PH_DUMMY = 3'h3,
        PH_DATA = 3'h4,
        PH_IGNORE = 3'h5
    } mior_phase_t;
    typedef enum logic [1:0] {
        K_DUAL_OUT = 2'h0,
        K_QUAD_OUT = 2'h1,
        K_DUAL_IO = 2'h2
    } mior_kind_t;
endpackage : mior_pkg

// ---- design/mior_top.sv ----
// Purpose: Device side of dual output, quad output and dual I/O reads
// Assumes: Serial clock and select sampled by clock_in, at least 8x slower
// Notes: Array reached through a read port whose data is taken in the strobe cycle, prefetched
// Contract
// R1: 3Bh 3/4-byte by wide bit; 3Ch 4-byte
// R2: Dual output drives two bits per falling edge
// R3: Zero or eight dummies before dual output
// R4: Input lines ignored during dummy cycles
// R5: Address advances one per byte output
// R6: Address wraps past top to zero
// R7: 6Bh 3/4-byte by wide bit; 6Ch 4-byte
// R8: Quad output drives nibble per falling edge
// R9: Quad reads only with quad enable set
// R10: Quad dummies ignore all four lines
// R11: BBh 3/4-byte by wide bit; BCh 4-byte
// R12: Dual I/O address two bits per rise
// R13: Plain table: opcode, address, latency, no mode
// R14: Mode table: four mode clocks after address
// R15: Mode Axh keeps continuous, next omits opcode
// R16: Only upper mode nibble decides continuation
// R17: Other mode leaves continuous at select rise
// R18: Short frame of eight clocks leaves continuous
// R19: Host releases lines by first data fall
// R20: Dual I/O data two bits per fall
// R21: Host keeps select low in mode/dummy
// R22: Wide bit selects 4-byte legacy addressing
// R23: Select high ends any read
// R24: Mode byte two bits per rise, MSB first
`timescale 1ns/1ps
`include "mior_cfg.svh"

module mior_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic flush_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready_out = cnt_q != DEPTH[AW:0];
    assign out_valid_out = cnt_q != '0;
    assign out_data_out = mem_q[rd_q];
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;

    always_ff @(posedge clock_in) begin
        if (push) begin
            mem_q[wr_q] <= in_data_in;
        end
    end

    // Flush beats push and pop so stale bytes never leak into a new read
    always_ff @(posedge clock_in) begin
        if (rst_in || flush_in) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule : mior_fifo

module mior_top (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe_out,
    input wire logic wide_address_enable_in,
    input wire logic quad_enable_in,
    input wire logic [1:0] latency_code_in,
    input wire logic mode_cycle_table_in,
    output logic mem_rd_out,
    output logic [31:0] mem_addr_out,
    input wire logic [7:0] mem_data_in,
    output logic cont_mode_out
);
    import mior_pkg::*;

    logic [2:0] sck_s;
    logic [2:0] cs_s;
    logic [3:0] io_s1;
    logic [3:0] io_s2;
    logic rise;
    logic fall;
    logic cs_high;
    logic cs_rise;
    mior_phase_t phase_q;
    mior_kind_t kind_q;
    logic wide_q;
    logic [5:0] cnt_q;
    logic [6:0] opc_q;
    logic [31:0] addr_q;
    logic [31:0] addr_nxt;
    logic [7:0] opc_nxt;
    logic [7:0] mode_nxt;
    logic [5:0] mode_q;
    logic mode_seen_q;
    logic mode_hit_q;
    logic cont_q;
    logic [3:0] frame_clks_q;
    logic [5:0] addr_clks;
    logic [5:0] dummy_clks;
    logic go_latency;
    logic fetch_go;
    logic fetching_q;
    logic pend_q;
    logic [31:0] fetch_addr_q;
    logic issue;
    logic flush;
    logic fifo_ready;
    logic fifo_valid;
    logic [7:0] fifo_data;
    logic pop;
    logic [1:0] unit_q;
    logic [7:0] out_sr_q;
    logic quad;
    logic dual_in;

    // Clock and select take three stages: first two synchronise, third only for edge finding; lines take two
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            sck_s <= 3'h0;
            cs_s <= 3'h7;
            io_s1 <= 4'h0;
            io_s2 <= 4'h0;
        end else begin
            sck_s <= {sck_s[1:0], sck_in};
            cs_s <= {cs_s[1:0], cs_n_in};
            io_s1 <= io_in;
            io_s2 <= io_s1;
        end
    end

    assign rise = sck_s[1] & ~sck_s[2] & ~cs_s[1];
    assign fall = ~sck_s[1] & sck_s[2] & ~cs_s[1];
    assign cs_high = cs_s[1];
    assign cs_rise = cs_s[1] & ~cs_s[2];
    assign quad = kind_q == K_QUAD_OUT;
    assign dual_in = kind_q == K_DUAL_IO;
    assign opc_nxt = {opc_q, io_s2[0]};
    assign mode_nxt = {mode_q, io_s2[1:0]};
    // Dual I/O shifts two bits per rise, io1 the more significant
    assign addr_nxt = dual_in ? {addr_q[29:0], io_s2[1:0]}
                              : {addr_q[30:0], io_s2[0]}; // [R12]
    assign addr_clks = dual_in ? (wide_q ? `MIOR_CLKS_A4_2 : `MIOR_CLKS_A3_2)
                               : (wide_q ? `MIOR_CLKS_A4_1 : `MIOR_CLKS_A3_1);
    // Latency code 3 means no dummies; others give the table figure
    assign dummy_clks = (latency_code_in == `MIOR_LAT_NO_DUMMY) ? 6'h00 :
                        dual_in ? `MIOR_DUMMY_DIO : `MIOR_DUMMY_OUT; // [R3]
    assign go_latency = rise && phase_q == PH_ADDR
                        && cnt_q == addr_clks - 6'h01;
    assign fetch_go = go_latency;

    // Command phase sequencing on serial clock rises
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            phase_q <= PH_OPCODE;
            kind_q <= K_DUAL_OUT;
            wide_q <= 1'b0;
            cnt_q <= 6'h00;
            opc_q <= 7'h00;
            addr_q <= 32'h00000000;
            mode_q <= 6'h00;
        end else if (cs_high) begin
            // Continuous mode starts the next frame at the address
            phase_q <= cont_q ? PH_ADDR : PH_OPCODE; // [R15] [R23]
            cnt_q <= 6'h00;
            opc_q <= 7'h00;
            addr_q <= 32'h00000000;
            if (cont_q) begin
                kind_q <= K_DUAL_IO;
            end
        end else if (rise) begin
            cnt_q <= cnt_q + 6'h01;
            unique case (phase_q)
                PH_OPCODE: begin
                    opc_q <= opc_nxt[6:0];
                    if (cnt_q == 6'h07) begin
                        cnt_q <= 6'h00;
                        phase_q <= PH_ADDR;
                        unique case (opc_nxt)
                            `MIOR_OP_DUAL, `MIOR_OP_DUAL_W: begin
                                kind_q <= K_DUAL_OUT; // [R1]
                            end
                            `MIOR_OP_QUAD, `MIOR_OP_QUAD_W: begin
                                kind_q <= K_QUAD_OUT; // [R7]
                                if (!quad_enable_in) begin
                                    phase_q <= PH_IGNORE; // [R9]
                                end
                            end
                            `MIOR_OP_DIO, `MIOR_OP_DIO_W: begin
                                kind_q <= K_DUAL_IO; // [R11]
                            end
                            default: begin
                                phase_q <= PH_IGNORE;
                            end
                        endcase
                        // Bit 2 marks the C opcodes, always 4 bytes
                        wide_q <= opc_nxt[2] // [R1] [R7] [R11] [R22]
                                  | wide_address_enable_in;
                    end
                end
                PH_ADDR: begin
                    addr_q <= addr_nxt;
                    if (go_latency) begin
                        cnt_q <= 6'h00;
                        if (dual_in && mode_cycle_table_in) begin
                            phase_q <= PH_MODE; // [R14]
                        end else if (dummy_clks == 6'h00) begin
                            phase_q <= PH_DATA; // [R13]
                        end else begin
                            phase_q <= PH_DUMMY;
                        end
                    end
                end
                PH_MODE: begin
                    mode_q <= mode_nxt[5:0]; // [R24]
                    if (cnt_q == `MIOR_MODE_CLKS - 6'h01) begin
                        cnt_q <= 6'h00;
                        phase_q <= (dummy_clks == 6'h00) ? PH_DATA
                                                        : PH_DUMMY;
                    end
                end
                PH_DUMMY: begin
                    // Lines are not looked at here
                    if (cnt_q == dummy_clks - 6'h01) begin
                        cnt_q <= 6'h00;
                        phase_q <= PH_DATA; // [R4] [R10]
                    end
                end
                PH_DATA: begin
                    cnt_q <= 6'h00;
                end
                PH_IGNORE: begin
                    cnt_q <= 6'h00;
                end
            endcase
        end
    end

    // Mode capture and continuous-mode bookkeeping
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            mode_seen_q <= 1'b0;
            mode_hit_q <= 1'b0;
            cont_q <= 1'b0;
            frame_clks_q <= 4'h0;
            cont_mode_out <= 1'b0;
        end else begin
            cont_mode_out <= cont_q;
            if (rise && frame_clks_q != 4'hF) begin
                frame_clks_q <= frame_clks_q + 4'h1;
            end
            if (rise && phase_q == PH_MODE
                && cnt_q == `MIOR_MODE_CLKS - 6'h01) begin
                mode_seen_q <= 1'b1;
                // Low nibble deliberately unused
                mode_hit_q <= mode_nxt[7:4] == `MIOR_MODE_CONT; // [R16]
            end
            if (cs_rise) begin
                mode_seen_q <= 1'b0;
                frame_clks_q <= 4'h0;
                if (mode_seen_q) begin
                    cont_q <= mode_hit_q; // [R15] [R17]
                end else if (cont_q
                             && frame_clks_q <= `MIOR_SHORT_FRAME) begin
                    cont_q <= 1'b0; // [R18]
                end
            end
        end
    end

    // Prefetch reads ahead; address moves one per array read issued
    assign flush = fetch_go | cs_high;
    assign issue = fetching_q & fifo_ready & ~pend_q & ~flush;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            fetching_q <= 1'b0;
            pend_q <= 1'b0;
            fetch_addr_q <= 32'h00000000;
            mem_rd_out <= 1'b0;
            mem_addr_out <= 32'h00000000;
        end else begin
            mem_rd_out <= issue;
            pend_q <= issue;
            if (cs_high) begin
                fetching_q <= 1'b0;
            end else if (fetch_go) begin
                fetching_q <= 1'b1;
                fetch_addr_q <= addr_nxt & `MIOR_ARRAY_TOP;
            end else if (issue) begin
                mem_addr_out <= fetch_addr_q;
                fetch_addr_q <= (fetch_addr_q == `MIOR_ARRAY_TOP)
                    ? 32'h00000000 : fetch_addr_q + 32'h00000001; // [R5] [R6]
            end
        end
    end

    mior_fifo #(
        .WIDTH(`MIOR_FIFO_WIDTH),
        .DEPTH(`MIOR_FIFO_DEPTH)
    ) u_fifo (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .flush_in(flush),
        .in_valid_in(pend_q & fetching_q),
        .in_ready_out(fifo_ready),
        .in_data_in(mem_data_in),
        .out_valid_out(fifo_valid),
        .out_ready_in(pop),
        .out_data_out(fifo_data)
    );

    assign pop = fall && phase_q == PH_DATA && unit_q == 2'h0 && fifo_valid;

    // Data out on falling edges; host has let go by the first one
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            io_out <= 4'h0;
            io_oe_out <= 4'h0;
            unit_q <= 2'h0;
            out_sr_q <= 8'h00;
        end else if (cs_high) begin
            io_oe_out <= 4'h0; // [R23]
            unit_q <= 2'h0;
        end else if (fall && phase_q == PH_DATA) begin
            io_oe_out <= quad ? 4'hF : 4'h3; // [R19]
            unit_q <= (unit_q == (quad ? 2'h1 : 2'h3)) ? 2'h0
                                                      : unit_q + 2'h1;
            if (unit_q == 2'h0) begin
                // Empty buffer sends the stale byte at its read slot rather than stall
                if (quad) begin
                    io_out <= fifo_data[7:4]; // [R8]
                    out_sr_q <= {fifo_data[3:0], 4'h0};
                end else begin
                    io_out <= {2'h0, fifo_data[7:6]}; // [R2] [R20]
                    out_sr_q <= {fifo_data[5:0], 2'h0};
                end
            end else if (quad) begin
                io_out <= out_sr_q[7:4]; // [R8]
                out_sr_q <= {out_sr_q[3:0], 4'h0};
            end else begin
                io_out <= {2'h0, out_sr_q[7:6]}; // [R2] [R20]
                out_sr_q <= {out_sr_q[5:0], 2'h0};
            end
        end
    end
endmodule : mior_top

// ---- verif/mior_monitor.sv ----
// Purpose: Port checker for the multi-wire read block
// Assumes: Serial clock period of eight system clocks
// Notes: Bound to mior_top below
`timescale 1ns/1ps
`include "mior_cfg.svh"
module mior_monitor (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic quad_enable_in,
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe_out,
    input wire logic mem_rd_out,
    input wire logic [31:0] mem_addr_out,
    input wire logic cont_mode_out
);
    logic [31:0] last_q;
    logic seen_q;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // Prefetch may run past select rise, so only reads inside a frame chain
    always_ff @(posedge clock_in) begin
        if (rst_in || cs_n_in) begin
            seen_q <= 1'b0;
        end else if (mem_rd_out) begin
            seen_q <= 1'b1;
        end
    end
    always_ff @(posedge clock_in) begin
        if (mem_rd_out) begin
            last_q <= mem_addr_out;
        end
    end
    AST_OE_SHAPE: assert property (
        io_oe_out inside {4'h0, 4'h3, 4'hF})
        else $error("output enable pattern illegal");
    AST_OE_OFF: assert property (cs_n_in [*5] |-> io_oe_out == 4'h0)
        else $error("lines still driven after select rise");
    AST_QUAD_GATE: assert property (
        io_oe_out == 4'hF |-> quad_enable_in)
        else $error("quad drive without quad enable");
    AST_RD_PULSE: assert property (mem_rd_out |=> !mem_rd_out)
        else $error("array read longer than one cycle");
    AST_ADDR_TOP: assert property (
        mem_rd_out |-> mem_addr_out <= `MIOR_ARRAY_TOP)
        else $error("array address beyond top");
    AST_ADDR_SEQ: assert property (
        mem_rd_out && seen_q && !cs_n_in
        |-> mem_addr_out == ((last_q + 32'h1) & `MIOR_ARRAY_TOP))
        else $error("array address not sequential");
    AST_CONT_AT_CS: assert property (
        $changed(cont_mode_out) |-> $past(cs_n_in, 2))
        else $error("continuous mode changed inside a frame");
    AST_DRIVE_ON_FALL: assert property (($changed(io_out)
        || $rose(io_oe_out != 4'h0)) && io_oe_out != 4'h0
        |-> !$past(sck_in, 3) && !cs_n_in)
        else $error("data changed away from a falling edge");
endmodule : mior_monitor

bind mior_top mior_monitor u_mon (.clock_in, .rst_in, .sck_in, .cs_n_in,
    .quad_enable_in, .io_out, .io_oe_out, .mem_rd_out, .mem_addr_out,
    .cont_mode_out);

// ---- verif/mior_host.sv ----
// Purpose: Host controller model for serial clock, select and lines
// Assumes: Mode 0, eight system clocks per serial clock
// Notes: Released lines are resolved by the bench
`timescale 1ns/1ps
module mior_host (
    input wire logic clock_in,
    input wire logic [3:0] line_in,
    output logic sck_out,
    output logic cs_n_out,
    output logic [3:0] io_out,
    output logic [3:0] io_oe_out
);
    logic [7:0] rx [$];
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        io_out = 4'h0;
        io_oe_out = 4'h0;
    end
    task automatic cyc(input logic [3:0] v, input logic [3:0] oe);
        sck_out <= 1'b0;
        io_out <= v;
        io_oe_out <= oe;
        repeat (4) @(posedge clock_in);
        sck_out <= 1'b1;
        repeat (4) @(posedge clock_in);
    endtask : cyc
    task automatic frame(input logic [7:0] op, input int nop,
        input logic [31:0] a, input int na, input int aw, input logic [7:0] m,
        input int nm, input int nd, input int dw, input int nb);
        logic [7:0] b;
        int k;
        rx.delete();
        @(posedge clock_in);
        cs_n_out <= 1'b0;
        repeat (2) @(posedge clock_in);
        for (k = 7; k > 7 - nop; k--) cyc({3'h0, op[k]}, 4'h1);
        for (k = na - aw; k >= 0; k -= aw) begin
            if (aw == 2) cyc({2'h0, a[k+1], a[k]}, 4'h3);
            else cyc({3'h0, a[k]}, 4'h1);
        end
        // Low mode nibble left floating to prove it is ignored
        for (k = 0; k < nm; k++) begin
            cyc({2'h0, m[7-2*k -: 2]}, k < 2 ? 4'h3 : 4'h0);
        end
        repeat (nd) cyc(4'h0, 4'h0);
        repeat (nb) begin
            for (k = 0; k < 8 / dw; k++) begin
                cyc(4'h0, 4'h0);
                b = dw == 4 ? {b[3:0], line_in} : {b[5:0], line_in[1:0]};
            end
            rx.push_back(b);
        end
        sck_out <= 1'b0;
        repeat (4) @(posedge clock_in);
        cs_n_out <= 1'b1;
        repeat (8) @(posedge clock_in);
    endtask : frame
endmodule : mior_host

// ---- verif/multi_io_flash_read_tb.sv ----
// Purpose: Self-checking bench for the multi-wire read block
// Assumes: Host model drives the link, bench models the array
// Notes: Array byte is a fixed function of its address
`timescale 1ns/1ps
`include "mior_cfg.svh"
module multi_io_flash_read_tb;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic wide = 1'b0;
    logic qen = 1'b0;
    logic mct = 1'b0;
    logic [1:0] lat = 2'h3;
    logic sck, cs_n, mem_rd, cont, oe_seen;
    logic [3:0] h_io, h_oe, d_io, d_oe, line;
    logic [3:0] flip = 4'h5;
    logic [31:0] mem_addr;
    logic [7:0] mem_data;
    int failures = 0;
    int n_tests = 0;
    int ticks = 0;
    always #20 clock_in = ~clock_in;
    // Floating lines toggle so a stale value never passes
    always @(posedge clock_in) flip <= ~flip;
    assign line = (h_oe & h_io) | (~h_oe & d_oe & d_io)
                  | (~h_oe & ~d_oe & flip);
    function automatic logic [7:0] pat(input logic [31:0] a);
        return a[7:0] ^ a[23:16] ^ 8'h5A;
    endfunction : pat
    // Array answers while its address stands, as the buffer push expects
    assign mem_data = pat(mem_addr);
    always @(posedge clock_in) if (d_oe != 4'h0) oe_seen <= 1'b1;
    mior_host host (.clock_in, .line_in(line), .sck_out(sck), .cs_n_out(cs_n),
        .io_out(h_io), .io_oe_out(h_oe));
    mior_top DUT (.clock_in, .rst_in, .sck_in(sck), .cs_n_in(cs_n),
        .io_in(line), .io_out(d_io), .io_oe_out(d_oe),
        .wide_address_enable_in(wide), .quad_enable_in(qen),
        .latency_code_in(lat), .mode_cycle_table_in(mct), .mem_rd_out(mem_rd),
        .mem_addr_out(mem_addr), .mem_data_in(mem_data), .cont_mode_out(cont));
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task automatic cfg(input logic w, input logic q, input logic [1:0] l,
        input logic t);
        @(posedge clock_in);
        wide <= w;
        qen <= q;
        lat <= l;
        mct <= t;
        oe_seen <= 1'b0;
    endtask : cfg
    task automatic rd(input logic [7:0] op, input int nop,
        input logic [31:0] a, input int na, input int aw, input logic [7:0] m,
        input int nm, input int nd, input int dw, input int nb);
        host.frame(op, nop, a, na, aw, m, nm, nd, dw, nb);
        chk("byte count", nb, host.rx.size());
        foreach (host.rx[i]) begin
            chk("data", pat((a + i) & `MIOR_ARRAY_TOP), host.rx[i]);
        end
        chk("drive off", 4'h0, d_oe);
    endtask : rd
    task automatic s_dual();
        cfg(1'b0, 1'b0, 2'h3, 1'b0);
        rd(`MIOR_OP_DUAL, 8, 32'h00123456, 24, 1, 0, 0,
            0, 2, 4);
        cfg(1'b0, 1'b0, 2'h0, 1'b0);
        rd(`MIOR_OP_DUAL_W, 8, 32'h03FFFFFE, 32, 1, 0, 0,
            8, 2, 4);
        cfg(1'b1, 1'b0, 2'h3, 1'b0);
        rd(`MIOR_OP_DUAL, 8, 32'h02ABCDEF, 32, 1, 0, 0, 0, 2, 2);
    endtask : s_dual
    task automatic s_quad();
        cfg(1'b0, 1'b1, 2'h0, 1'b0);
        rd(`MIOR_OP_QUAD, 8, 32'h00000F0F, 24, 1, 0, 0,
            8, 4, 3);
        cfg(1'b0, 1'b1, 2'h3, 1'b0);
        rd(`MIOR_OP_QUAD_W, 8, 32'h01000010, 32, 1, 0, 0,
            0, 4, 2);
        cfg(1'b0, 1'b0, 2'h3, 1'b0);
        host.frame(`MIOR_OP_QUAD, 8, 32'h10, 24, 1, 0, 0, 0, 4, 2);
        chk("quad refused", 1'b0, oe_seen);
    endtask : s_quad
    task automatic s_dio();
        cfg(1'b0, 1'b0, 2'h3, 1'b0);
        rd(`MIOR_OP_DIO, 8, 32'h00345678, 24, 2,
            0, 0, 0, 2, 3);
        cfg(1'b1, 1'b0, 2'h0, 1'b1);
        rd(`MIOR_OP_DIO, 8, 32'h01234567, 32, 2, 8'hA5, 4,
            4, 2, 2);
        chk("continuous set", 1'b1, cont);
        rd(8'h00, 0, 32'h00000100, 32, 2, 8'h3F, 4, 4, 2, 2);
        chk("continuous left", 1'b0, cont);
        rd(`MIOR_OP_DIO_W, 8, 32'h00000200, 32, 2, 8'hA0, 4,
            4, 2, 1);
        chk("continuous again", 1'b1, cont);
        host.frame(8'h00, 0, 32'h0, 8, 2, 0, 0, 0, 2, 0);
        chk("short frame", 1'b0, cont);
        rd(`MIOR_OP_DUAL, 8, 32'h00000300, 32, 1, 0, 0, 8, 2, 1);
    endtask : s_dio
    task automatic print_verdict();
        if (failures == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    always @(posedge clock_in) begin
        ticks++;
        if (ticks == 40000) begin
            failures++;
            print_verdict();
        end
    end
    initial begin
        repeat (12) @(posedge clock_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge clock_in);
        s_dual();
        s_quad();
        s_dio();
        print_verdict();
    end
endmodule : multi_io_flash_read_tb
